// File: supervisor_reset_watchdog.sv
// top of the supervisor reset watchdog: reset generation, manual clear filter, watchdog
// assumes supplyGood from an external comparator, all inputs synchronous to sysClk
// Overview of operation
// - any trigger holds active-low reset low for the hold-off period
// - reset stays low while supply bad or manual clear low
// - hold-off follows supply recovery, watchdog timeout, or manual clear release
// - manual clear low asserts reset, held and for hold-off after release
// - active-high reset output is always inverse of active-low output
// - kick input stuck high or low past timeout triggers reset
// - any reset or kick edge clears watchdog counter; short pulses seen
// - watchdog counter held clear during reset, counts right after release
// - floating kick input effectively disables the watchdog
// - device drives kick low first seven eighths, high final eighth
// - internal drive edge clears the counter before timeout when unconnected
// - supply going bad restarts the hold-off timer
// - bouncing switch on manual clear needs no external debounce
// - manual clear ignores short low pulses, acts on pulses of 1 us
`timescale 1ns/1ps
module supervisor_reset_watchdog
    import supervisor_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_OFF_CYCLES,
    parameter int DOG_CYCLES = DOG_TIMEOUT_CYCLES,
    parameter int FILTER_CYCLES = CLEAR_FILTER_CYCLES
) (
    input wire logic sysClk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic supplyGood,
    input wire logic manual_clear_n,
    input wire logic kick_input,
    output reset_pair_t resetPair,
    output kick_drive_t kickDrive
);
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam int DW = $clog2(DOG_CYCLES + 1);
    localparam int FW = $clog2(FILTER_CYCLES + 1);
    localparam logic [DW-1:0] DOG_LAST = DW'(DOG_CYCLES - 1);
    localparam logic [DW-1:0] SERVICE_POINT = DW'((DOG_CYCLES / SERVICE_DEN) * SERVICE_NUM);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
    localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN = 3'b100
    } sup_state_t;

    sup_state_t state;
    logic [HW-1:0] holdCount;
    logic [DW-1:0] dogCount;
    logic [FW-1:0] filterCount;
    logic clearActive;
    logic kickLast;
    logic kickEdge;
    logic dogExpire;
    logic holdCause;

    // manual clear low must persist before acting; bounce restarts it
    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            filterCount <= '0;
            clearActive <= 1'b0;
        end else if (clkEn) begin
            if (manual_clear_n) begin
                filterCount <= '0;
                clearActive <= 1'b0;
            end else if (filterCount == FILTER_LAST) begin
                clearActive <= 1'b1;
            end else begin
                filterCount <= filterCount + 1'b1;
            end
        end
    end

    assign holdCause = !supplyGood || clearActive;

    // reset sequencer: hold while cause present, then timed hold-off
    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            state <= ST_HOLD;
            holdCount <= '0;
        end else if (clkEn) begin
            unique case (state)
                ST_HOLD: begin
                    holdCount <= '0;
                    if (!holdCause) begin
                        state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (holdCause) begin
                        state <= ST_HOLD;
                        holdCount <= '0;
                    end else if (holdCount == HOLD_LAST) begin
                        state <= ST_RUN;
                    end else begin
                        holdCount <= holdCount + 1'b1;
                    end
                end
                ST_RUN: begin
                    holdCount <= '0;
                    if (holdCause) begin
                        state <= ST_HOLD;
                    end else if (dogExpire) begin
                        state <= ST_DELAY;
                    end
                end
            endcase
        end
    end

    // kick edge detect; one sampled cycle at 40 ns covers 50 ns pulses
    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            kickLast <= 1'b0;
        end else if (clkEn) begin
            kickLast <= kick_input;
        end
    end

    assign kickEdge = kick_input != kickLast;

    // watchdog counter
    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            dogCount <= '0;
        end else if (clkEn) begin
            if (state != ST_RUN || kickEdge) begin
                dogCount <= '0;
            end else if (dogCount != DOG_LAST) begin
                dogCount <= dogCount + 1'b1;
            end
        end
    end

    assign dogExpire = state == ST_RUN && !kickEdge && dogCount == DOG_LAST;

    // internal weak drive of the kick pin from the counter chain
    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            kickDrive <= '{driveValue: 1'b0, driveEnable: 1'b1};
        end else if (clkEn) begin
            kickDrive.driveEnable <= 1'b1;
            kickDrive.driveValue <= dogCount >= SERVICE_POINT;
        end
    end

    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            resetPair <= '{resetOutN: 1'b0, resetOut: 1'b1};
        end else if (clkEn) begin
            resetPair.resetOutN <= state == ST_RUN && !holdCause && !dogExpire;
            resetPair.resetOut <= !(state == ST_RUN && !holdCause && !dogExpire);
        end
    end
endmodule // supervisor_reset_watchdog

// File: supervisor_pkg.sv
// constants and carrier types for the supervisor reset watchdog
// assumes a 25 MHz system clock
package supervisor_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int HOLD_OFF_MS = 200;
    localparam int HOLD_OFF_CYCLES = HOLD_OFF_MS * (CLK_HZ / 1000);
    localparam int DOG_TIMEOUT_MS = 1600;
    localparam int DOG_TIMEOUT_CYCLES = DOG_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int KICK_PULSE_NS = 50;
    localparam int KICK_PULSE_CYCLES = (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_IGNORE_NS = 100;
    localparam int CLEAR_ACT_NS = 1000;
    // low pulse must last this many cycles before it acts
    localparam int CLEAR_FILTER_CYCLES = CLEAR_ACT_NS / CLK_PERIOD_NS;
    localparam int SERVICE_NUM = 7;
    localparam int SERVICE_DEN = 8;

    typedef struct packed {
        logic resetOutN;
        logic resetOut;
    } reset_pair_t;

    typedef struct packed {
        logic driveValue;
        logic driveEnable;
    } kick_drive_t;
endpackage

// File: supervisor_assertions.sv
// port checker for the supervisor reset watchdog
// assumes a short HOLD_CYCLES and clkEn low only while no cause is present
`timescale 1ns/1ps
module supervisor_assertions
    import supervisor_pkg::*;
#(
    parameter int HOLD_CYCLES = 20
) (
    input wire logic sysClk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic supplyGood,
    input wire logic manual_clear_n,
    input wire logic kick_input,
    input reset_pair_t resetPair,
    input kick_drive_t kickDrive
);
    default clocking @(posedge sysClk); endclocking
    default disable iff (reset);
    logic lastKick;
    logic [7:0] stillCnt;
    // cycles the kick pin has stood still out of reset
    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            lastKick <= 1'b0;
            stillCnt <= 8'h0;
        end else begin
            lastKick <= kick_input;
            stillCnt <= (kick_input != lastKick || !resetPair.resetOutN) ? 8'h0 : stillCnt + 8'h1;
        end
    end
    inv_out_a: assert property (resetPair.resetOut == !resetPair.resetOutN) else $error("outputs not inverse");
    supply_low_a: assert property (!supplyGood |-> ##[1:2] !resetPair.resetOutN) else $error("supply low");
    hold_a: assert property ($fell(resetPair.resetOutN) |=> !resetPair.resetOutN [*8]) else $error("short hold");
    clear_low_a: assert property (!manual_clear_n [*6] |-> ##[0:2] !resetPair.resetOutN) else $error("clear");
    release_a: assert property ($rose(resetPair.resetOutN) |-> $past(supplyGood, HOLD_CYCLES)
        && $past(manual_clear_n, HOLD_CYCLES)) else $error("early release");
    stuck_bound_a: assert property (stillCnt < 8'h48) else $error("no expiry");
    cause_fall_a: assert property ($fell(resetPair.resetOutN) |-> !$past(supplyGood) || !$past(supplyGood, 2)
        || !$past(manual_clear_n, 2) || stillCnt > 8'h3c) else $error("reset without cause");
    drive_late_a: assert property ($rose(kickDrive.driveValue) |-> stillCnt > 8'h30) else $error("early");
    drive_en_a: assert property (kickDrive.driveEnable) else $error("weak drive off");
endmodule // supervisor_assertions
bind supervisor_reset_watchdog supervisor_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) supervisor_assertions_inst (
    .sysClk, .reset, .clkEn, .supplyGood, .manual_clear_n, .kick_input, .resetPair, .kickDrive);

// File: host_kick_model.sv
// host side of the kick pin: floats, stands still, or pulses
// assumes the supervisor's weak drive on the pin
`timescale 1ns/1ps
module host_kick_model
    import supervisor_pkg::*;
(
    input wire logic sysClk,
    input wire logic [1:0] hostMode,
    input kick_drive_t kickDrive,
    output logic kickPin
);
    logic [5:0] tick = 6'h0;
    always_ff @(posedge sysClk) tick <= (tick == 6'h27) ? 6'h0 : tick + 6'h1;
    always_comb begin
        case (hostMode)
            2'h1: kickPin = 1'b0;
            2'h2: kickPin = (tick == 6'h0);
            default: kickPin = kickDrive.driveEnable ? kickDrive.driveValue : tick[0];
        endcase
    end
endmodule // host_kick_model

// File: supervisor_reset_watchdog_bench.sv
// bench for the supervisor reset watchdog
// assumes HOLD 20, DOG 64, FILTER 4 cycles
`timescale 1ns/1ps
module supervisor_reset_watchdog_bench;
    import supervisor_pkg::*;
    logic sysClk = 0, reset = 1, supplyGood = 0, clearN = 1, kickPin;
    logic clkEn = 1;
    logic [1:0] hostMode = 2'h0;
    reset_pair_t resetPair;
    kick_drive_t kickDrive;
    int fails = 0, nTests = 0, n;
    initial forever #20 sysClk = ~sysClk;
    supervisor_reset_watchdog #(.HOLD_CYCLES(20), .DOG_CYCLES(64), .FILTER_CYCLES(4)) supervisor_reset_watchdog_inst (
        .sysClk(sysClk), .reset(reset), .clkEn(clkEn), .supplyGood(supplyGood), .manual_clear_n(clearN),
        .kick_input(kickPin), .resetPair(resetPair), .kickDrive(kickDrive));
    host_kick_model host_kick_model_inst (.sysClk(sysClk), .hostMode(hostMode), .kickDrive(kickDrive), .kickPin(kickPin));
    task check(input logic [7:0] seen, exp);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge sysClk);
    endtask
    // bounded wait for the reset output to reach a level
    task wait_out(input logic v);
        n = 0;
        while (resetPair.resetOutN !== v && n < 200) begin
            cyc(1);
            n++;
        end
    endtask
    task t_powerup;
        cyc(10);
        check(8'(resetPair), 8'h01);
        supplyGood = 1;
        cyc(10);
        supplyGood = 0;
        cyc(2);
        supplyGood = 1;
        wait_out(1);
        check(8'(n >= 20 && n <= 23), 8'h01);
        check(8'(resetPair), 8'h02);
    endtask
    task t_clear;
        clearN = 0;
        cyc(2);
        clearN = 1;
        cyc(4);
        check(8'(resetPair.resetOutN), 8'h01);
        clearN = 0;
        cyc(1);
        clearN = 1;
        cyc(1);
        clearN = 0;
        cyc(10);
        check(8'(resetPair.resetOutN), 8'h00);
        clearN = 1;
        wait_out(1);
        check(8'(n >= 20 && n <= 23), 8'h01);
    endtask
    task t_dog;
        hostMode = 2'h1;
        wait_out(0);
        check(8'(n <= 70), 8'h01);
        wait_out(1);
        hostMode = 2'h2;
        cyc(300);
        check(8'(resetPair.resetOutN), 8'h01);
        hostMode = 2'h0;
        cyc(300);
        check(8'(resetPair.resetOutN), 8'h01);
    endtask
    // clock enable low freezes the hold-off count mid-way
    task t_freeze;
        supplyGood = 0;
        cyc(2);
        check(8'(resetPair), 8'h01);
        supplyGood = 1;
        cyc(5);
        clkEn = 0;
        cyc(50);
        check(8'(resetPair), 8'h01);
        clkEn = 1;
        wait_out(1);
        check(8'(n), 8'h11);
        check(8'(resetPair), 8'h02);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        cyc(4);
        reset = 0;
        t_powerup;
        t_clear;
        t_dog;
        t_freeze;
        print_verdict;
    end
    initial begin
        #200us;
        fails++;
        print_verdict;
    end
endmodule // supervisor_reset_watchdog_bench
